// ===== logic/fault_sup_pkg.sv
// constants, register map and carrier types of the drive fault supervisor
// Notes on behaviour
// - any fault stops the drive; each fault is type 1 or type 2
// - type 1 fault with tries above 0 loads the restart delay countdown
// - countdown at zero: if cause is gone, clear fault and issue start
// - type 2 fault never auto-clears; clears only once its cause is gone
// - active fault flashes the fault number and the fault indicator
// - escape acknowledges and blanks the display; fault stays latched
// - latest fault code stays readable after acknowledgement
// - stop key clears a resettable fault when stop mode is 0 to 3
// - writing 1 or 2 to fault clear clears the fault; so does power cycle
// - digital input selected as option 10 clears the fault when cycled
// - tries nonzero, delay 0: undervolt, overvolt, heatsink clear quietly
// - open auxiliary interlock raises fault 2, type 1
// - older firmware: start undervolt, ripple or phase loss give fault 3
// - bus undervoltage raises fault 4, overvoltage fault 5, both type 1
// - stall raises type 1 fault 6, overload trip type 1 fault 7
// - heatsink overtemperature raises type 1 fault 8
// - hardware overcurrent raises type 2 fault 12, ground fault code 13
// - all restart attempts failed raises type 2 fault 33
package fault_sup_pkg;
    localparam int CLK_PERIOD_NS   = 4;
    localparam int TICK_NS         = 1000000;
    localparam int TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int START_WINDOW_MS = 200;
    localparam int FLASH_HALF_MS   = 500;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONFIG  = 8'h00;
    localparam logic [7:0] OFF_DELAY   = 8'h04;
    localparam logic [7:0] OFF_DIN_SEL = 8'h08;
    localparam logic [7:0] OFF_CLEAR   = 8'h0c;
    localparam logic [7:0] OFF_STATUS  = 8'h10;
    localparam logic [7:0] OFF_LATEST  = 8'h14;
    localparam logic [7:0] OFF_INT_ST  = 8'h18;
    localparam logic [7:0] OFF_INT_MSK = 8'h1c;

    localparam logic [7:0] CLR_CMD_A     = 8'h01;
    localparam logic [7:0] CLR_CMD_B     = 8'h02;
    localparam logic [7:0] DIN_CLEAR_OPT = 8'h0a;
    localparam logic [3:0] STOP_MODE_MAX = 4'h3;

    localparam logic [7:0] CODE_AUX   = 8'h02;
    localparam logic [7:0] CODE_PLOSS = 8'h03;
    localparam logic [7:0] CODE_UV    = 8'h04;
    localparam logic [7:0] CODE_OV    = 8'h05;
    localparam logic [7:0] CODE_STALL = 8'h06;
    localparam logic [7:0] CODE_OL    = 8'h07;
    localparam logic [7:0] CODE_HS    = 8'h08;
    localparam logic [7:0] CODE_HWOC  = 8'h0c;
    localparam logic [7:0] CODE_GND   = 8'h0d;
    localparam logic [7:0] CODE_TRIES = 8'h21;

    // source order is priority order, lowest index wins
    localparam int NSRC = 9;
    localparam logic [7:0] SRC_CODE [NSRC] = '{CODE_HWOC, CODE_GND,
        CODE_PLOSS, CODE_AUX, CODE_UV, CODE_OV, CODE_STALL, CODE_OL, CODE_HS};
    localparam logic [NSRC-1:0] SRC_TYPE2 = 9'h007;

    localparam int NEV        = 4;
    localparam int EV_TRIP    = 0;
    localparam int EV_CLEAR   = 1;
    localparam int EV_RESTART = 2;
    localparam int EV_EXHAUST = 3;

    typedef struct packed {
        logic [7:0] tries;
        logic [3:0] stop_mode;
        logic       older_fw;
    } cfg_t;
    localparam cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic [7:0] tries_left;
        logic       acked;
        logic       type2;
        logic       active;
    } status_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_HELD = 3'b010,
        S_WAIT = 3'b100
    } state_t;
endpackage : fault_sup_pkg

// ===== logic/ms_tick_gen.sv
// millisecond timebase pulse generator
`timescale 1ns/1ns
`default_nettype none
module ms_tick_gen #(
    parameter int TICK_CYCLES = fault_sup_pkg::TICK_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      tick
);
    logic [31:0] cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(TICK_CYCLES - 1)) begin
            cnt  <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : ms_tick_gen
`default_nettype wire

// ===== logic/drive_fault_supervisor.sv
// fault latch, clear paths, auto restart and apb registers of the drive
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module drive_fault_supervisor #(
    parameter int TICK_CYCLES = fault_sup_pkg::TICK_CYCLES
) (
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        AUX_INTERLOCK_OPEN,
    input  wire logic        BUS_UNDERVOLT,
    input  wire logic        BUS_OVERVOLT,
    input  wire logic        BUS_RIPPLE,
    input  wire logic        PHASE_LOSS,
    input  wire logic        MOTOR_STALL,
    input  wire logic        MOTOR_OVERLOAD,
    input  wire logic        HEATSINK_OVERTEMP,
    input  wire logic        HW_OVERCURRENT,
    input  wire logic        GROUND_FAULT,
    input  wire logic        START_CMD,
    input  wire logic        KEY_ESC,
    input  wire logic        KEY_STOP,
    input  wire logic [3:0]  DIGITAL_IN,
    output logic             DRIVE_STOP,
    output logic             AUTO_START,
    output logic [7:0]       DISP_CODE,
    output logic             DISP_FLASH,
    output logic             FAULT_LED,
    output logic             IRQ
);
    localparam int NSRC = fault_sup_pkg::NSRC;

    fault_sup_pkg::cfg_t   cfg;
    fault_sup_pkg::state_t state;
    fault_sup_pkg::state_t next_state;
    fault_sup_pkg::status_t status;
    logic [15:0]     auto_restart_delay;
    logic [31:0]     digital_input_function_selectors;
    logic [15:0]     timer;
    logic [7:0]      tries_left;
    logic [7:0]      code;
    logic [7:0]      latest_fault_code;
    logic            type2;
    logic            acked;
    logic [7:0]      win_cnt;
    logic [9:0]      flash_cnt;
    logic            flash_phase;
    logic [3:0]      din_prev;
    logic [3:0]      din_hit;
    logic [NSRC-1:0] cond;
    logic [NSRC-1:0] match;
    logic [7:0]      pick_code;
    logic            pick_type2;
    logic            cond_now;
    logic            power_loss;
    logic            tick;
    logic            wr;
    logic            fault_clear_command;
    logic            manual;
    logic            quiet_code;
    logic            quiet_clear;
    logic            attempt;
    logic            do_latch;
    logic            do_clear;
    logic            do_restart;
    logic            do_exhaust;
    logic [fault_sup_pkg::NEV-1:0] int_status;
    logic [fault_sup_pkg::NEV-1:0] int_mask;
    logic [fault_sup_pkg::NEV-1:0] events;

    ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .tick  (tick)
    );

    // fault sources; older firmware folds supply losses into one code
    assign power_loss = cfg.older_fw & ((BUS_UNDERVOLT & (win_cnt != 8'h0))
                        | BUS_RIPPLE | PHASE_LOSS);
    assign cond = {HEATSINK_OVERTEMP, MOTOR_OVERLOAD, MOTOR_STALL,
                   BUS_OVERVOLT, BUS_UNDERVOLT, AUX_INTERLOCK_OPEN,
                   power_loss, GROUND_FAULT, HW_OVERCURRENT};

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_src
            assign match[gi] = cond[gi]
                & (fault_sup_pkg::SRC_CODE[gi] == code);
        end
        for (gi = 0; gi < 4; gi++) begin : g_din
            assign din_hit[gi] = din_prev[gi] & ~DIGITAL_IN[gi]
                & (digital_input_function_selectors[gi*8 +: 8]
                   == fault_sup_pkg::DIN_CLEAR_OPT);
        end
    endgenerate

    always_comb begin
        pick_code  = 8'h0;
        pick_type2 = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (cond[i]) begin
                pick_code  = fault_sup_pkg::SRC_CODE[i];
                pick_type2 = fault_sup_pkg::SRC_TYPE2[i];
            end
        end
    end

    assign cond_now   = |match;
    assign wr         = PSEL & PENABLE & PREADY & PWRITE;
    assign fault_clear_command = wr & (PADDR == fault_sup_pkg::OFF_CLEAR)
        & ((PWDATA[7:0] == fault_sup_pkg::CLR_CMD_A)
           | (PWDATA[7:0] == fault_sup_pkg::CLR_CMD_B));
    assign manual = (KEY_STOP & ~type2
                     & (cfg.stop_mode <= fault_sup_pkg::STOP_MODE_MAX))
                    | fault_clear_command | (|din_hit);
    assign quiet_code = (code == fault_sup_pkg::CODE_UV)
                        | (code == fault_sup_pkg::CODE_OV)
                        | (code == fault_sup_pkg::CODE_HS);
    assign quiet_clear = (state == fault_sup_pkg::S_HELD) & ~type2
        & (cfg.tries != 8'h0) & (auto_restart_delay == 16'h0)
        & quiet_code & ~cond_now;
    assign attempt    = (state == fault_sup_pkg::S_WAIT) & (timer == 16'h0);
    assign do_latch   = (state == fault_sup_pkg::S_IDLE) & (|cond);
    assign do_restart = attempt & ~cond_now;
    // a manual clear in the same cycle wins over running out of tries
    assign do_exhaust = attempt & cond_now & (tries_left <= 8'h1)
                        & ~manual;
    assign do_clear   = (state != fault_sup_pkg::S_IDLE)
        & ((manual & (~type2 | ~cond_now)) | do_restart | quiet_clear);
    assign events = {do_exhaust, do_restart, do_clear, do_latch};

    always_comb begin
        next_state = state;
        case (state)
            fault_sup_pkg::S_IDLE: begin
                if (do_latch) begin
                    if (!pick_type2 && tries_left != 8'h0
                        && auto_restart_delay != 16'h0) begin
                        next_state = fault_sup_pkg::S_WAIT;
                    end else begin
                        next_state = fault_sup_pkg::S_HELD;
                    end
                end
            end
            fault_sup_pkg::S_HELD: begin
                if (do_clear) begin
                    next_state = fault_sup_pkg::S_IDLE;
                end
            end
            fault_sup_pkg::S_WAIT: begin
                if (do_clear) begin
                    next_state = fault_sup_pkg::S_IDLE;
                end else if (do_exhaust) begin
                    next_state = fault_sup_pkg::S_HELD;
                end
            end
            default: next_state = fault_sup_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= fault_sup_pkg::S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // fault record; power cycling clears it through reset
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            code  <= 8'h0;
            type2 <= 1'b0;
        end else if (do_exhaust) begin
            code  <= fault_sup_pkg::CODE_TRIES;
            type2 <= 1'b1;
        end else if (do_latch) begin
            code  <= pick_code;
            type2 <= pick_type2;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            latest_fault_code <= 8'h0;
        end else if (do_exhaust) begin
            latest_fault_code <= fault_sup_pkg::CODE_TRIES;
        end else if (do_latch) begin
            latest_fault_code <= pick_code;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            acked <= 1'b0;
        end else if (do_latch || do_exhaust) begin
            acked <= 1'b0;
        end else if (KEY_ESC && state != fault_sup_pkg::S_IDLE) begin
            acked <= 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timer <= 16'h0;
        end else if (do_latch) begin
            timer <= auto_restart_delay;
        end else if (attempt && cond_now) begin
            timer <= auto_restart_delay;
        end else if (tick && timer != 16'h0) begin
            timer <= timer - 16'h1;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            tries_left <= 8'h0;
        end else if ((wr && PADDR == fault_sup_pkg::OFF_CONFIG)) begin
            tries_left <= PWDATA[12:5];
        end else if (do_clear && !do_restart && !quiet_clear) begin
            tries_left <= cfg.tries;
        end else if (attempt && tries_left != 8'h0) begin
            tries_left <= tries_left - 8'h1;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            win_cnt <= 8'h0;
        end else if (START_CMD) begin
            win_cnt <= 8'(fault_sup_pkg::START_WINDOW_MS);
        end else if (tick && win_cnt != 8'h0) begin
            win_cnt <= win_cnt - 8'h1;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            flash_cnt   <= 10'h0;
            flash_phase <= 1'b0;
        end else if (tick) begin
            if (flash_cnt == 10'(fault_sup_pkg::FLASH_HALF_MS - 1)) begin
                flash_cnt   <= 10'h0;
                flash_phase <= ~flash_phase;
            end else begin
                flash_cnt <= flash_cnt + 10'h1;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            din_prev <= 4'h0;
        end else begin
            din_prev <= DIGITAL_IN;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            DRIVE_STOP <= 1'b0;
            AUTO_START <= 1'b0;
            DISP_CODE  <= 8'h0;
            DISP_FLASH <= 1'b0;
            FAULT_LED  <= 1'b0;
        end else begin
            DRIVE_STOP <= next_state != fault_sup_pkg::S_IDLE;
            AUTO_START <= do_restart;
            DISP_CODE  <= code;
            DISP_FLASH <= (state != fault_sup_pkg::S_IDLE) & ~acked
                          & flash_phase;
            FAULT_LED  <= (state != fault_sup_pkg::S_IDLE) & ~acked
                          & flash_phase;
        end
    end

    // configuration registers
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg                <= fault_sup_pkg::CFG_RESET;
            auto_restart_delay <= 16'h0;
            digital_input_function_selectors <= 32'h0;
            int_mask           <= '0;
        end else if (wr) begin
            if (PADDR == fault_sup_pkg::OFF_CONFIG) begin
                cfg <= PWDATA[12:0];
            end else if (PADDR == fault_sup_pkg::OFF_DELAY) begin
                auto_restart_delay <= PWDATA[15:0];
            end else if (PADDR == fault_sup_pkg::OFF_DIN_SEL) begin
                digital_input_function_selectors <= PWDATA;
            end else if (PADDR == fault_sup_pkg::OFF_INT_MSK) begin
                int_mask <= PWDATA[fault_sup_pkg::NEV-1:0];
            end
        end
    end

    // sticky events, write one to clear, a new event wins
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            int_status <= '0;
        end else if (wr && PADDR == fault_sup_pkg::OFF_INT_ST) begin
            int_status <= (int_status & ~PWDATA[fault_sup_pkg::NEV-1:0])
                          | events;
        end else begin
            int_status <= int_status | events;
        end
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_status & int_mask);
        end
    end

    assign status = {tries_left, acked, type2,
                     state != fault_sup_pkg::S_IDLE};

    // one wait-free access phase: answer registered during setup
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
            if (PSEL && !PENABLE) begin
                if (PADDR == fault_sup_pkg::OFF_CONFIG) begin
                    PRDATA <= 32'(cfg);
                end else if (PADDR == fault_sup_pkg::OFF_DELAY) begin
                    PRDATA <= 32'(auto_restart_delay);
                end else if (PADDR == fault_sup_pkg::OFF_DIN_SEL) begin
                    PRDATA <= digital_input_function_selectors;
                end else if (PADDR == fault_sup_pkg::OFF_CLEAR) begin
                    PRDATA <= 32'h0;
                end else if (PADDR == fault_sup_pkg::OFF_STATUS) begin
                    PRDATA <= 32'(status);
                end else if (PADDR == fault_sup_pkg::OFF_LATEST) begin
                    PRDATA <= 32'(latest_fault_code);
                end else if (PADDR == fault_sup_pkg::OFF_INT_ST) begin
                    PRDATA <= 32'(int_status);
                end else if (PADDR == fault_sup_pkg::OFF_INT_MSK) begin
                    PRDATA <= 32'(int_mask);
                end else begin
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence arm_s;
        do_latch && !pick_type2 && tries_left != 8'h0
            && auto_restart_delay != 16'h0;
    endsequence
    sequence good_try_s;
        attempt && !cond_now;
    endsequence

    stop_on_fault_a: assert property (do_latch |=> DRIVE_STOP)
        else $error("fault did not stop the drive");
    fault_class_a: assert property (
        do_latch |=> type2 == $past(pick_type2) && code == $past(pick_code))
        else $error("fault class or code not latched");
    timer_load_a: assert property (
        arm_s |=> state == fault_sup_pkg::S_WAIT
            && timer == $past(auto_restart_delay))
        else $error("restart countdown not loaded");
    restart_a: assert property (good_try_s |=> AUTO_START
            && state == fault_sup_pkg::S_IDLE)
        else $error("auto restart did not clear and start");
    type2_hold_a: assert property (
        state != fault_sup_pkg::S_IDLE && type2 && cond_now
            |=> state != fault_sup_pkg::S_IDLE)
        else $error("type 2 fault cleared with cause present");
    flash_show_a: assert property (
        state != fault_sup_pkg::S_IDLE && !acked && flash_phase
            |=> DISP_FLASH && FAULT_LED)
        else $error("fault display not flashing");
    esc_ack_a: assert property (
        KEY_ESC && state != fault_sup_pkg::S_IDLE && !do_clear && !do_exhaust
            |=> acked && state != fault_sup_pkg::S_IDLE ##1 !DISP_FLASH)
        else $error("escape handling wrong");
    latest_code_a: assert property (
        do_latch |=> latest_fault_code == $past(pick_code))
        else $error("latest fault code not recorded");
    stop_clear_a: assert property (
        state != fault_sup_pkg::S_IDLE && !type2 && KEY_STOP
            && cfg.stop_mode <= fault_sup_pkg::STOP_MODE_MAX
            |=> state == fault_sup_pkg::S_IDLE)
        else $error("stop key did not clear resettable fault");
    tries_out_a: assert property (
        do_exhaust |=> code == fault_sup_pkg::CODE_TRIES && type2
            && state == fault_sup_pkg::S_HELD)
        else $error("exhausted tries fault not raised");
endmodule : drive_fault_supervisor
`default_nettype wire

// ===== dv/fault_cond_model.sv
// keypad and condition monitor model facing the fault supervisor
`timescale 1ns/1ns
`default_nettype none
module fault_cond_model (
    input  wire logic       clk,
    output logic      [9:0] cond,
    output logic            esc,
    output logic            stop,
    output logic      [3:0] din
);
    initial begin
        cond = '0;
        esc = 1'h0;
        stop = 1'h0;
        din = 4'hf;
    end
    task automatic set_cond(input int i, input logic v);
        @(posedge clk);
        cond[i] <= v;
    endtask : set_cond
    // a key press lasts one cycle
    task automatic press(input logic is_stop);
        @(posedge clk);
        {stop, esc} <= is_stop ? 2'h2 : 2'h1;
        @(posedge clk);
        {stop, esc} <= 2'h0;
    endtask : press
    task automatic din_cycle(input int i);
        @(posedge clk);
        din[i] <= 1'h0;
        @(posedge clk);
        din[i] <= 1'h1;
    endtask : din_cycle
endmodule : fault_cond_model
`default_nettype wire

// ===== dv/test_drive_fault_supervisor.sv
// self-checking bench for the drive fault supervisor
`timescale 1ns/1ns
`default_nettype none
module test_drive_fault_supervisor;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic        start = 1'h0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, slv, esc, stp, drv_stop, auto_start;
    logic        disp_flash, fault_led, irq;
    logic [7:0]  disp_code;
    logic [9:0]  cond;
    logic [3:0]  din;
    int          err_total = 0;
    int          cmp_count = 0;
    always #2 clk = ~clk;
    drive_fault_supervisor #(.TICK_CYCLES(10)) i_drive_fault_supervisor (
        .MCLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr),
        .AUX_INTERLOCK_OPEN(cond[0]), .BUS_UNDERVOLT(cond[1]),
        .BUS_OVERVOLT(cond[2]), .BUS_RIPPLE(cond[3]), .PHASE_LOSS(cond[4]),
        .MOTOR_STALL(cond[5]), .MOTOR_OVERLOAD(cond[6]),
        .HEATSINK_OVERTEMP(cond[7]), .HW_OVERCURRENT(cond[8]),
        .GROUND_FAULT(cond[9]), .START_CMD(start), .KEY_ESC(esc),
        .KEY_STOP(stp), .DIGITAL_IN(din), .DRIVE_STOP(drv_stop),
        .AUTO_START(auto_start), .DISP_CODE(disp_code),
        .DISP_FLASH(disp_flash), .FAULT_LED(fault_led), .IRQ(irq));
    fault_cond_model i_model (
        .clk(clk), .cond(cond), .esc(esc), .stop(stp), .din(din));
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        rd = prdata;
        slv = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
        if (n >= 20) begin
            err_total++;
            stop_test();
        end
    endtask : apb
    task automatic sts(logic [31:0] e);
        apb(1'h0, fault_sup_pkg::OFF_STATUS, 32'h0);
        chk("status", e, rd);
    endtask : sts
    task automatic clr(logic [31:0] v, logic e);
        apb(1'h1, fault_sup_pkg::OFF_CLEAR, v);
        repeat (2) @(posedge clk);
        chk("drive stop", {31'h0, e}, {31'h0, drv_stop});
    endtask : clr
    task automatic trip(int i, logic [7:0] code);
        i_model.set_cond(i, 1'h1);
        repeat (3) @(posedge clk);
        chk("drive stop", 32'h1, {31'h0, drv_stop});
        chk("code", {24'h0, code}, {24'h0, disp_code});
    endtask : trip
    task automatic t_ack;
        int on;
        on = 0;
        sts(32'h0);
        apb(1'h0, 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, slv});
        apb(1'h1, fault_sup_pkg::OFF_INT_MSK, 32'h1);
        trip(2, fault_sup_pkg::CODE_OV);
        repeat (11000) begin
            @(posedge clk);
            on += int'(disp_flash & fault_led);
        end
        chk("flash", 32'h1, {31'h0, on > 4000 && on < 7000});
        chk("irq", 32'h1, {31'h0, irq});
        i_model.press(1'h0);
        repeat (3) @(posedge clk);
        chk("flash off", 32'h0, {30'h0, disp_flash, fault_led});
        sts(32'h5);
        apb(1'h0, fault_sup_pkg::OFF_LATEST, 32'h0);
        chk("latest", 32'h5, rd);
        i_model.set_cond(2, 1'h0);
        clr(32'h1, 1'h0);
        apb(1'h1, fault_sup_pkg::OFF_INT_ST, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'h0, fault_sup_pkg::OFF_INT_ST, 32'h0);
        chk("events", 32'h2, rd);
        $display("test ack done");
    endtask : t_ack
    task automatic t_type2;
        trip(8, fault_sup_pkg::CODE_HWOC);
        sts(32'h3);
        i_model.press(1'h1);
        clr(32'h2, 1'h1);
        i_model.set_cond(8, 1'h0);
        clr(32'h2, 1'h0);
        trip(9, fault_sup_pkg::CODE_GND);
        i_model.set_cond(9, 1'h0);
        clr(32'h1, 1'h0);
        $display("test type2 done");
    endtask : t_type2
    task automatic t_clear;
        apb(1'h1, fault_sup_pkg::OFF_CONFIG, 32'h6);
        trip(1, fault_sup_pkg::CODE_UV);
        i_model.set_cond(1, 1'h0);
        i_model.press(1'h1);
        clr(32'h0, 1'h0);
        apb(1'h1, fault_sup_pkg::OFF_DIN_SEL, 32'h0a000000);
        trip(0, fault_sup_pkg::CODE_AUX);
        i_model.set_cond(0, 1'h0);
        i_model.din_cycle(0);
        clr(32'h0, 1'h1);
        i_model.din_cycle(3);
        clr(32'h0, 1'h0);
        $display("test clear done");
    endtask : t_clear
    task automatic t_restart;
        int n;
        apb(1'h1, fault_sup_pkg::OFF_CONFIG, 32'h40);
        apb(1'h1, fault_sup_pkg::OFF_DELAY, 32'h2);
        trip(5, fault_sup_pkg::CODE_STALL);
        i_model.set_cond(5, 1'h0);
        for (n = 0; n < 200 && auto_start !== 1'h1; n++)
            @(posedge clk);
        chk("auto start", 32'h1, {31'h0, auto_start});
        clr(32'h0, 1'h0);
        sts(32'h8);
        trip(6, fault_sup_pkg::CODE_OL);
        repeat (80) @(posedge clk);
        apb(1'h0, fault_sup_pkg::OFF_LATEST, 32'h0);
        chk("latest", 32'h21, rd);
        i_model.set_cond(6, 1'h0);
        clr(32'h0, 1'h1);
        clr(32'h1, 1'h0);
        sts(32'h12);
        apb(1'h1, fault_sup_pkg::OFF_DELAY, 32'h0);
        trip(7, fault_sup_pkg::CODE_HS);
        i_model.set_cond(7, 1'h0);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            n += int'(auto_start);
        end
        chk("quiet clear", 32'h0, {31'h0, drv_stop} | n);
        $display("test restart done");
    endtask : t_restart
    task automatic t_ploss;
        apb(1'h1, fault_sup_pkg::OFF_CONFIG, 32'h1);
        @(posedge clk);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        trip(1, fault_sup_pkg::CODE_PLOSS);
        sts(32'h3);
        i_model.set_cond(1, 1'h0);
        clr(32'h1, 1'h0);
        trip(3, fault_sup_pkg::CODE_PLOSS);
        i_model.set_cond(3, 1'h0);
        clr(32'h2, 1'h0);
        trip(4, fault_sup_pkg::CODE_PLOSS);
        i_model.set_cond(4, 1'h0);
        clr(32'h1, 1'h0);
        $display("test power loss done");
    endtask : t_ploss
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        t_ack();
        t_type2();
        t_clear();
        t_restart();
        t_ploss();
        stop_test();
    end
endmodule : test_drive_fault_supervisor
`default_nettype wire
